// >>> src/rci_top.sv
// reset-cause recording, status flag update and program counter selection
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`include "rci_regs.svh"
module rci_top
#(
   parameter int PC_W = 13
)
(
   input  wire logic                sys_clk,
   input  wire logic                resetn,
   input  wire rci_pkg::rci_req_t   cause_req,
   input  wire logic                sleeping,
   input  wire logic                global_irq_enable,
   input  wire logic [PC_W-1:0]     cur_pc,
   output logic                     cpu_hold,
   output logic                     pc_load,
   output logic      [PC_W-1:0]     pc_value,
   output logic                     init_strobe,
   output rci_pkg::rci_init_t       init_class,
   output logic      [7:0]          wake_flag_set,
   output logic      [7:0]          core_status,
   output logic      [1:0]          reset_cause_flags,
   output logic                     irq,
   input  wire logic [7:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   input  wire logic [3:0]          avs_byteenable,
   output logic      [31:0]         avs_readdata,
   output logic                     avs_waitrequest
);

   ////////////////////////////////////////////////////////////////////////
   // sequencer: take a cause, apply it, then release the core

   rci_pkg::rci_state_t state;
   rci_pkg::rci_state_t next_state;
   rci_pkg::rci_cause_t cur_code;
   logic                cur_sleep;
   logic                cur_ien;
   logic [7:0]          cur_wake;
   logic [PC_W-1:0]     cur_pc_q;

   wire take  = (state == rci_pkg::RCI_ST_IDLE) && cause_req.valid;
   wire apply = (state == rci_pkg::RCI_ST_APPLY);

   always_comb
   begin
      case (state)
         rci_pkg::RCI_ST_IDLE:
            next_state = take ? rci_pkg::RCI_ST_APPLY : rci_pkg::RCI_ST_IDLE;
         rci_pkg::RCI_ST_APPLY:
            next_state = rci_pkg::RCI_ST_RELEASE;
         rci_pkg::RCI_ST_RELEASE:
            next_state = rci_pkg::RCI_ST_IDLE;
         default:
            next_state = rci_pkg::RCI_ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         state <= rci_pkg::RCI_ST_RELEASE;
      else
         state <= next_state;
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cur_code  <= rci_pkg::RCI_CAUSE_POR;
         cur_sleep <= 1'b0;
         cur_ien   <= 1'b0;
         cur_wake  <= 8'h00;
         cur_pc_q  <= '0;
      end
      else if (take)
      begin
         cur_code  <= cause_req.code;
         cur_sleep <= sleeping;
         cur_ien   <= global_irq_enable;
         cur_wake  <= cause_req.wake_src;
         cur_pc_q  <= cur_pc;
      end
   end

   // core stays held while the flags settle
   assign cpu_hold = take || apply; // RULE_13

   ////////////////////////////////////////////////////////////////////////
   // cause decode

   wire is_por      = (cur_code == rci_pkg::RCI_CAUSE_POR);
   wire is_brownout = (cur_code == rci_pkg::RCI_CAUSE_BROWNOUT);
   wire is_ext      = (cur_code == rci_pkg::RCI_CAUSE_EXT);
   wire is_watchdog = (cur_code == rci_pkg::RCI_CAUSE_WATCHDOG);
   wire is_irqwk    = (cur_code == rci_pkg::RCI_CAUSE_IRQWK);
   wire dog_wake    = is_watchdog && cur_sleep;
   wire is_wake     = dog_wake || is_irqwk;

   // timeout and power-down per cause, bank bits cleared on any true reset
   wire [7:0] st_pwr  = `RCI_ST_RESET | (core_status & 8'h07); // RULE_01 RULE_02
   wire [7:0] st_dogr = (core_status & 8'h07) | 8'h08; // RULE_02
   wire [7:0] st_dogw = core_status & 8'hE7; // RULE_02
   wire [7:0] st_extr = core_status & `RCI_ST_BANK_MASK; // RULE_03
   wire [7:0] st_exts = (core_status & 8'h07) | 8'h10; // RULE_04
   wire [7:0] st_irqw = (core_status & 8'hE7) | 8'h10; // RULE_04

   wire [7:0] st_hw =
      (is_por || is_brownout)   ? st_pwr  :
      (is_ext && !cur_sleep)    ? st_extr :
      is_ext                    ? st_exts :
      dog_wake                  ? st_dogw :
      is_watchdog               ? st_dogr :
                                  st_irqw;

   wire [1:0] cf_hw =
      is_por ? {1'b0, reset_cause_flags[`RCI_CF_BROWNOUT]} : // RULE_01 RULE_11
      is_brownout ? {reset_cause_flags[`RCI_CF_POWER_ON], 1'b0} : // RULE_02
               reset_cause_flags;                             // RULE_11

   wire [PC_W-1:0] pc_next_instr = cur_pc_q + PC_W'(1);
   wire [PC_W-1:0] pc_hw =
      (is_irqwk && cur_ien) ? PC_W'(`RCI_PC_IRQ_VECTOR) : // RULE_06
      is_wake               ? pc_next_instr :           // RULE_05
                              PC_W'(`RCI_PC_RESET);    // RULE_05

   rci_pkg::rci_init_t init_hw;
   assign init_hw = is_wake ? rci_pkg::RCI_INIT_WAKE :
                    (is_por || is_brownout) ? rci_pkg::RCI_INIT_POWER :
                    rci_pkg::RCI_INIT_RESET; // RULE_08

   // a wake-up always leaves at least one source flag set
   wire [7:0] wake_hw = (cur_wake == 8'h00) ? 8'h01 : cur_wake; // RULE_07

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   logic bus_ack;
   wire  bus_req  = avs_read || avs_write;
   // a write lands only at the edge that completes the transfer
   wire  bus_wr   = avs_write && bus_ack && avs_byteenable[0];
   wire  sel_st   = (avs_address == `RCI_OFS_CORE_STATUS);
   wire  sel_cf   = (avs_address == `RCI_OFS_CAUSE_FLAGS);
   wire  sel_is   = (avs_address == `RCI_OFS_IRQ_STATUS);
   wire  sel_im   = (avs_address == `RCI_OFS_IRQ_MASK);
   wire  sel_lc   = (avs_address == `RCI_OFS_LAST_CAUSE);
   wire  [7:0] wd = avs_writedata[7:0];

   assign avs_waitrequest = bus_req && !bus_ack;

   logic [4:0] evt_status;
   logic [4:0] evt_mask;
   logic [4:0] evt_set;
   assign evt_set = apply ? (5'h01 << cur_code) : 5'h00;

   // unimplemented bits read as zero
   wire [31:0] rd_mux =
      sel_st ? {24'h0, core_status} :
      sel_cf ? {30'h0, reset_cause_flags} : // RULE_09
      sel_is ? {27'h0, evt_status} :
      sel_im ? {27'h0, evt_mask} :
      sel_lc ? {29'h0, cur_code} : 32'h0; // RULE_09

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bus_ack      <= 1'b0;
         avs_readdata <= 32'h0;
      end
      else
      begin
         bus_ack      <= bus_req && !bus_ack;
         avs_readdata <= (avs_read && !bus_ack) ? rd_mux : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags, program counter and init class

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         core_status       <= `RCI_ST_RESET; // RULE_01
         reset_cause_flags <= `RCI_CF_RESET; // RULE_01
      end
      else if (apply)
      begin
         core_status       <= st_hw;
         reset_cause_flags <= cf_hw;
      end
      else if (bus_wr && sel_st)
         core_status <= (wd & `RCI_ST_SW_MASK)
                      | (core_status & ~`RCI_ST_SW_MASK);
      else if (bus_wr && sel_cf)
         reset_cause_flags <= wd[1:0]; // RULE_11 RULE_12
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pc_value      <= PC_W'(`RCI_PC_RESET);
         init_class    <= rci_pkg::RCI_INIT_POWER;
         init_strobe   <= 1'b1;
         wake_flag_set <= 8'h00;
      end
      else
      begin
         pc_value      <= apply ? pc_hw : pc_value;
         init_class    <= apply ? init_hw : init_class;
         init_strobe   <= apply;
         wake_flag_set <= (apply && is_wake) ? wake_hw : 8'h00; // RULE_07
      end
   end

   // load the pc as the core is let go
   assign pc_load = (state == rci_pkg::RCI_ST_RELEASE); // RULE_13

   rci_flag_bank #(.N(5)) u_flags
   (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .set_evt    (evt_set),
      .clr_w1c    ((bus_wr && sel_is) ? wd[4:0] : 5'h00),
      .mask_we    (bus_wr && sel_im),
      .mask_wdata (wd[4:0]),
      .status     (evt_status),
      .mask       (evt_mask),
      .irq        (irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // assertions

   sequence s_take;
      take;
   endsequence

   sequence s_settle;
      apply && cpu_hold ##1 pc_load && !cpu_hold;
   endsequence

   a_hold_release: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_13
      s_take |=> s_settle)
      else $error("core released before flags settled");

   a_por_flags: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_01
      (apply && is_por) |=> !reset_cause_flags[1] && core_status[4:3] == 2'b11
         && reset_cause_flags[0] == $past(reset_cause_flags[0]))
      else $error("power-on flags wrong");

   a_brownout_flags: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_02
      (apply && is_brownout) |=> reset_cause_flags[0] == 1'b0
         && core_status[4:3] == 2'b11
         && reset_cause_flags[1] == $past(reset_cause_flags[1]))
      else $error("brown-out flags wrong");

   a_dog_codes: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_02
      (apply && is_watchdog) |=>
         core_status[4:3] == ($past(cur_sleep) ? 2'b00 : 2'b01))
      else $error("watchdog flags wrong");

   a_ext_running: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_03
      (apply && is_ext && !cur_sleep) |=> core_status[7:5] == 3'b000
         && core_status[4:0] == $past(core_status[4:0]) && pc_value == '0)
      else $error("pin reset while running wrong");

   a_sleep_exit: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_04
      (apply && (is_irqwk || (is_ext && cur_sleep))) |=> core_status[4:3] == 2'b10)
      else $error("sleep exit flags wrong");

   a_pc_select: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_05
      (apply && is_wake && !(is_irqwk && cur_ien)) |=>
         pc_value == $past(cur_pc_q) + PC_W'(1)
         ##1 pc_value == $past(pc_value))
      else $error("wake pc wrong");

   a_irq_vector: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_06
      (take && cause_req.code == rci_pkg::RCI_CAUSE_IRQWK && global_irq_enable)
         |=> ##1 pc_load && pc_value == PC_W'(`RCI_PC_IRQ_VECTOR))
      else $error("interrupt vector not loaded");

   a_wake_flag: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_07
      (apply && is_wake) |=> wake_flag_set != 8'h00 ##1 wake_flag_set == 8'h00)
      else $error("no wake source flag");

   a_init_class: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_08
      (apply && (is_por || is_brownout)) |=> init_strobe
         && init_class == rci_pkg::RCI_INIT_POWER)
      else $error("init class wrong");

   a_unimpl_zero: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_09
      bus_ack && $past(avs_read) |-> avs_readdata[31:8] == 24'h0)
      else $error("unimplemented bits not zero");

   a_por_only: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_11
      (apply && !is_por) |=> reset_cause_flags[1] == $past(reset_cause_flags[1]))
      else $error("power-on flag touched");

endmodule

// >>> src/rci_regs.svh
// register map, field positions, reset values and vectors of the reset-cause block
// Operation
// [RULE_01] A power-on reset clears the power-on flag, sets timeout and power-down, and leaves the brown-out flag as it was.
// [RULE_02] Brown-out gives power-on 1, brown-out 0, timeout 1, power-down 1; watchdog reset gives timeout 0, power-down 1; watchdog wake-up gives both 0.
// On a brown-out the code leaves the power-on flag as it was instead of setting it.
// [RULE_03] An external-pin reset while running keeps timeout and power-down, clears the three bank and page bits and loads the program counter with zero.
// [RULE_04] An external-pin reset in sleep and an interrupt wake-up set timeout and clear power-down.
// [RULE_05] Power-on, brown-out, external-pin and watchdog resets load the program counter with zero; wake-ups continue after the sleep instruction.
// [RULE_06] An interrupt wake-up with the global interrupt enable set loads the interrupt vector instead.
// [RULE_07] A wake-up leaves the wake source flag set in the interrupt flag registers and keeps the rest of them.
// [RULE_08] Register initialisation falls into three classes: power-on and brown-out, external-pin and watchdog reset, and wake-up.
// [RULE_09] Unimplemented bits always read back as zero.
// [RULE_10] Software keeps reserved bits at zero when writing.
// [RULE_11] The power-on flag is cleared only by a power-on reset; software sets it afterwards.
// [RULE_12] Software sets the brown-out flag after power-on so a later zero marks a brown-out.
// [RULE_13] The cause flags are final before the core is released to fetch its first instruction.
`ifndef RCI_REGS_SVH
`define RCI_REGS_SVH

`define RCI_OFS_CORE_STATUS  8'h00
`define RCI_OFS_CAUSE_FLAGS  8'h04
`define RCI_OFS_IRQ_STATUS   8'h08
`define RCI_OFS_IRQ_MASK     8'h0C
`define RCI_OFS_LAST_CAUSE   8'h10

`define RCI_ST_TIMEOUT       4
`define RCI_ST_POWERDOWN     3
`define RCI_CF_POWER_ON      1
`define RCI_CF_BROWNOUT      0

`define RCI_ST_RESET         8'h18
`define RCI_CF_RESET         2'h0
`define RCI_ST_SW_MASK       8'hE7
`define RCI_ST_BANK_MASK     8'h1F

`define RCI_PC_RESET         13'h0000
`define RCI_PC_IRQ_VECTOR    13'h0004

`endif

// >>> src/rci_pkg.sv
// types shared by the reset-cause block
package rci_pkg;

   typedef enum logic [2:0]
   {
      RCI_CAUSE_POR      = 3'h0,
      RCI_CAUSE_BROWNOUT = 3'h1,
      RCI_CAUSE_EXT      = 3'h2,
      RCI_CAUSE_WATCHDOG = 3'h3,
      RCI_CAUSE_IRQWK    = 3'h4
   } rci_cause_t;

   typedef enum logic [1:0]
   {
      RCI_ST_IDLE    = 2'h0,
      RCI_ST_APPLY   = 2'h1,
      RCI_ST_RELEASE = 2'h2
   } rci_state_t;

   typedef enum logic [1:0]
   {
      RCI_INIT_POWER = 2'h0,
      RCI_INIT_RESET = 2'h1,
      RCI_INIT_WAKE  = 2'h2
   } rci_init_t;

   // one reset or wake-up request from the supply, pin, watchdog and interrupt logic
   typedef struct packed
   {
      logic       valid;
      rci_cause_t code;
      logic [7:0] wake_src;
   } rci_req_t;

endpackage

// >>> src/rci_flag_bank.sv
// sticky event flags with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ns
module rci_flag_bank
#(
   parameter int N = 5
)
(
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic [N-1:0] set_evt,
   input  wire logic [N-1:0] clr_w1c,
   input  wire logic         mask_we,
   input  wire logic [N-1:0] mask_wdata,
   output logic      [N-1:0] status,
   output logic      [N-1:0] mask,
   output logic              irq
);

   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_flag
         // a set in the same cycle as a clear wins
         always_ff @(posedge sys_clk or negedge resetn)
         begin
            if (!resetn)
               status[i] <= 1'b0;
            else if (set_evt[i])
               status[i] <= 1'b1;
            else if (clr_w1c[i])
               status[i] <= 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         mask <= '0;
      else if (mask_we)
         mask <= mask_wdata;
   end

   assign irq = |(status & mask);

   a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
      (set_evt != '0) |=> ((status & $past(set_evt)) == $past(set_evt)))
      else $error("event flag lost");

endmodule

// >>> verification/tb_top.sv
// self-checking bench for the reset-cause block
`timescale 1ns/1ns
`include "rci_regs.svh"
module tb_top;
   logic               sys_clk;
   logic               resetn;
   rci_pkg::rci_req_t  cause_req;
   logic               sleeping;
   logic               global_irq_enable;
   logic [12:0]        cur_pc;
   logic               cpu_hold;
   logic               pc_load;
   logic [12:0]        pc_value;
   logic               init_strobe;
   rci_pkg::rci_init_t init_class;
   logic [7:0]         wake_flag_set;
   logic [7:0]         core_status;
   logic [1:0]         reset_cause_flags;
   logic               irq;
   logic [7:0]         avs_address;
   logic               avs_read;
   logic               avs_write;
   logic [31:0]        avs_writedata;
   logic [3:0]         avs_byteenable;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   int                 fail_count;
   int                 n_compared;
   int                 cycles;
   int                 seed;
   int                 i;
   logic [7:0]         m_st;
   logic [1:0]         m_cf;
   logic [4:0]         m_ev;
   logic [31:0]        rd;
   logic [2:0]         c;
   logic               slp;

   rci_top dut
   (
      .sys_clk           (sys_clk),
      .resetn            (resetn),
      .cause_req         (cause_req),
      .sleeping          (sleeping),
      .global_irq_enable (global_irq_enable),
      .cur_pc            (cur_pc),
      .cpu_hold          (cpu_hold),
      .pc_load           (pc_load),
      .pc_value          (pc_value),
      .init_strobe       (init_strobe),
      .init_class        (init_class),
      .wake_flag_set     (wake_flag_set),
      .core_status       (core_status),
      .reset_cause_flags (reset_cause_flags),
      .irq               (irq),
      .avs_address       (avs_address),
      .avs_read          (avs_read),
      .avs_write         (avs_write),
      .avs_writedata     (avs_writedata),
      .avs_byteenable    (avs_byteenable),
      .avs_readdata      (avs_readdata),
      .avs_waitrequest   (avs_waitrequest)
   );

   //////////////////////////////////////////////////////////////////////////
   always #50 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask

   // one bus access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      do
      begin
         @(posedge sys_clk);
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   //////////////////////////////////////////////////////////////////////////
   function automatic logic is_wake(input logic [2:0] k, input logic s);
      is_wake = (k == 3'h4) || (k == 3'h3 && s);
   endfunction

   function automatic logic [7:0] exp_st(input logic [2:0] k,
                                        input logic s, input logic [7:0] v);
      case (k)
         3'h0, 3'h1: exp_st = {3'h0, 2'h3, v[2:0]};
         3'h2: exp_st = s ? {3'h0, 2'h2, v[2:0]} : {3'h0, v[4:0]};
         3'h3: exp_st = s ? {v[7:5], 2'h0, v[2:0]} : {3'h0, 2'h1, v[2:0]};
         default: exp_st = {v[7:5], 2'h2, v[2:0]};
      endcase
   endfunction

   function automatic logic [12:0] exp_pc(input logic [2:0] k,
                                          input logic s, input logic g,
                                          input logic [12:0] p);
      if (k == 3'h4 && g)
         exp_pc = `RCI_PC_IRQ_VECTOR;
      else if (is_wake(k, s))
         exp_pc = p + 13'h1;
      else
         exp_pc = `RCI_PC_RESET;
   endfunction

   // one cause request, checked at the release cycle
   task automatic cause(input logic [2:0] k, input logic s, input logic g,
                        input logic [12:0] p, input logic [7:0] src);
      int n;
      logic [7:0] ms;
      logic [1:0] ecl;
      logic [7:0] ewf;
      n = 0;
      ms = (k == 3'h0) ? 8'hF8 : 8'hFF;
      ecl = (k < 3'h2) ? 2'h0 : (is_wake(k, s) ? 2'h2 : 2'h1);
      ewf = is_wake(k, s) ? ((src == 8'h00) ? 8'h01 : src) : 8'h00;
      @(posedge sys_clk);
      cause_req <= '{1'b1, rci_pkg::rci_cause_t'(k), src};
      sleeping <= s;
      global_irq_enable <= g;
      cur_pc <= p;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (cpu_hold !== 1'b1 && n < 20);
      cause_req.valid <= 1'b0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pc_load !== 1'b1 && n < 40);
      m_st = exp_st(k, s, m_st);
      if (k == 3'h0)
         m_cf = {1'b0, m_cf[0]};
      if (k == 3'h1)
         m_cf = {m_cf[1], 1'b0};
      m_ev = m_ev | (5'h01 << k);
      chk("pc_value", {19'h0, exp_pc(k, s, g, p)}, {19'h0, pc_value});
      chk("status", {24'h0, m_st & ms}, {24'h0, core_status & ms});
      chk("flags", {30'h0, m_cf}, {30'h0, reset_cause_flags});
      chk("init_class", {30'h0, ecl}, {30'h0, init_class});
      chk("wake_flags", {24'h0, ewf}, {24'h0, wake_flag_set});
      chk("init_strobe", 32'h1, {31'h0, init_strobe});
      bus(1'b0, `RCI_OFS_LAST_CAUSE, 32'h0, 4'hF, rd);
      chk("last_cause", {29'h0, k}, rd);
      if (k == 3'h0)
      begin
         bus(1'b1, `RCI_OFS_CORE_STATUS, 32'hE7, 4'hF, rd);
         m_st = 8'hFF;
      end
   endtask

   //////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      resetn = 1'b0;
      cause_req = '0;
      sleeping = 1'b0;
      global_irq_enable = 1'b0;
      cur_pc = 13'h0000;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      fail_count = 0;
      n_compared = 0;
      cycles = 0;
      seed = 32'h21B6;
      m_ev = 5'h00;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      bus(1'b0, `RCI_OFS_CORE_STATUS, 32'h0, 4'hF, rd);
      chk("status_reset", 32'h18, rd);
      bus(1'b0, `RCI_OFS_CAUSE_FLAGS, 32'h0, 4'hF, rd);
      chk("flags_reset", 32'h0, rd);
      bus(1'b0, 8'h14, 32'h0, 4'hF, rd);
      chk("unmapped", 32'h0, rd);
      $display("test reset values done");
      bus(1'b1, `RCI_OFS_CAUSE_FLAGS, 32'h3, 4'hF, rd);
      m_cf = 2'h3;
      bus(1'b1, `RCI_OFS_CORE_STATUS, 32'h0, 4'hF, rd);
      bus(1'b0, `RCI_OFS_CORE_STATUS, 32'h0, 4'hF, rd);
      chk("status_ro", 32'h18, rd);
      bus(1'b1, `RCI_OFS_CORE_STATUS, 32'hE7, 4'hF, rd);
      bus(1'b1, `RCI_OFS_CORE_STATUS, 32'h0, 4'h0, rd);
      bus(1'b0, `RCI_OFS_CORE_STATUS, 32'h0, 4'hF, rd);
      chk("status_rw", 32'hFF, rd);
      m_st = 8'hFF;
      $display("test register access done");
      cause(3'h2, 1'b0, 1'b0, 13'h0123, 8'h00);
      cause(3'h2, 1'b1, 1'b0, 13'h0123, 8'h00);
      cause(3'h3, 1'b0, 1'b0, 13'h0456, 8'h00);
      cause(3'h3, 1'b1, 1'b1, 13'h1FFF, 8'h20);
      cause(3'h4, 1'b1, 1'b0, 13'h0789, 8'h00);
      cause(3'h4, 1'b1, 1'b1, 13'h0789, 8'h82);
      cause(3'h1, 1'b0, 1'b0, 13'h0ABC, 8'h00);
      cause(3'h0, 1'b1, 1'b1, 13'h0DEF, 8'h00);
      $display("test each cause done");
      for (i = 0; i < 40; i++)
      begin
         c = 3'($unsigned($random(seed)) % 5);
         slp = (c == 3'h4) ? 1'b1 : 1'($random(seed));
         cause(c, slp, 1'($random(seed)), 13'($random(seed)),
               8'($random(seed)));
      end
      $display("test random causes done");
      bus(1'b0, `RCI_OFS_IRQ_STATUS, 32'h0, 4'hF, rd);
      chk("event_status", {27'h0, m_ev}, rd);
      chk("irq_masked", 32'h0, {31'h0, irq});
      bus(1'b1, `RCI_OFS_IRQ_MASK, 32'h1F, 4'hF, rd);
      bus(1'b0, `RCI_OFS_IRQ_MASK, 32'h0, 4'hF, rd);
      chk("event_mask", 32'h1F, rd);
      @(posedge sys_clk);
      chk("irq_raised", 32'h1, {31'h0, irq});
      bus(1'b1, `RCI_OFS_IRQ_STATUS, 32'h1F, 4'hF, rd);
      @(posedge sys_clk);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      bus(1'b0, `RCI_OFS_IRQ_STATUS, 32'h0, 4'hF, rd);
      chk("event_clear", 32'h0, rd);
      $display("test interrupt done");
      give_verdict();
   end
endmodule
